// [sim/lgbm_master.sv]
// Object access master on the fieldbus side
`timescale 1ns/10ps
`default_nettype none
module lgbm_master (
  input wire logic clock,
  output logic req,
  output logic req_write,
  output logic req_obj,
  output logic [7:0] req_sub,
  output logic [7:0] req_wdata
);
  initial begin
    {req, req_write, req_obj, req_sub, req_wdata} = '0;
  end
  // Any byte value is legal, so any beam may be masked
  task automatic access(input logic w, o, input logic [7:0] s, d);
    @(posedge clock);
    #1 {req, req_write, req_obj, req_sub, req_wdata} = {1'b1, w, o, s, d};
  endtask : access
  // Released data is scrambled so no stale byte looks valid
  task automatic idle();
    @(posedge clock);
    #1 {req, req_wdata} = {1'b0, ~req_wdata};
  endtask : idle
endmodule : lgbm_master
`default_nettype wire

// [sim/lgbm_top_props.sv]
// Assertions on the ports of the beam status and mask block
`timescale 1ns/10ps
`default_nettype none
module lgbm_top_props (
  input wire logic clock,
  input wire logic rst,
  input wire logic [lgbm_pkg::BEAMS-1:0] beam_made,
  input wire logic req,
  input wire logic req_write,
  input wire logic req_obj,
  input wire logic [7:0] req_sub,
  input wire logic ack_q,
  input wire logic err_q,
  input wire logic [7:0] rdata_q,
  input wire logic [lgbm_pkg::BEAMS-1:0] status_pdo_q
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  wire logic [7:0] rev_first = {<<{beam_made[7:0]}};
  sequence rd_s; req && !req_write; endsequence
  sequence wr_s; req && req_write; endsequence
  ack_every_a: assert property (req |=> ack_q) else $error("no answer");
  ack_only_a: assert property (!req |=> !ack_q && !err_q && rdata_q == 8'h00)
    else $error("stray answer");
  count_read_a: assert property (
    rd_s ##0 req_sub == 8'h00 |=> rdata_q == 8'h1e && !err_q)
    else $error("bad count");
  status_ro_a: assert property (wr_s ##0 !req_obj |=> err_q)
    else $error("status written");
  count_ro_a: assert property (wr_s ##0 req_sub == 8'h00 |=> err_q)
    else $error("count written");
  sub_range_a: assert property (req && req_sub > 8'h1e |=> err_q && rdata_q == 8'h00)
    else $error("range kept");
  pdo_delay_a: assert property (!$past(rst) && !$past(rst, 2) |->
    status_pdo_q == $past(beam_made, 2)) else $error("pdo image");
  // Stable input only, the sample edge is loose
  stat_order_a: assert property (
    rd_s ##0 !req_obj && req_sub == 8'h01 && $stable(beam_made) && !$past(rst)
    |=> rdata_q == $past(rev_first)) else $error("status order");
endmodule : lgbm_top_props
bind lgbm_top lgbm_top_props chk (.clock(clock), .rst(rst), .beam_made(beam_made), .req(req),
  .req_write(req_write), .req_obj(req_obj), .req_sub(req_sub), .ack_q(ack_q), .err_q(err_q),
  .rdata_q(rdata_q), .status_pdo_q(status_pdo_q));
`default_nettype wire

// [sim/tb_top.sv]
// Self-checking bench of the beam status and mask block
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin err_total++; \
  $display("BAD %0t got %h want %h", $time, a, b); end end
module tb_top;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic [lgbm_pkg::BEAMS-1:0] beam_made = '0;
  logic req, req_write, req_obj, ack_q, err_q;
  logic [7:0] req_sub, req_wdata, rdata_q, m [1:30];
  logic [lgbm_pkg::BEAMS-1:0] status_pdo_q, active_mask_q, watched_blocked_q;
  logic [8:0] exp_q [$];
  logic [8:0] exp_v;
  logic [lgbm_pkg::BEAMS-1:0] exp_act;
  int err_total = 0, num_checks = 0, cyc = 0;
  always #4 clock = ~clock;
  lgbm_master ma (.clock(clock), .req(req), .req_write(req_write), .req_obj(req_obj),
    .req_sub(req_sub), .req_wdata(req_wdata));
  lgbm_top #(.APPLY_CYCLES(8)) DUT (.clock(clock), .rst(rst), .beam_made(beam_made),
    .req(req), .req_write(req_write), .req_obj(req_obj), .req_sub(req_sub),
    .req_wdata(req_wdata), .ack_q(ack_q), .err_q(err_q), .rdata_q(rdata_q),
    .status_pdo_q(status_pdo_q), .active_mask_q(active_mask_q),
    .watched_blocked_q(watched_blocked_q));
  ////////////////////////////////////////
  function automatic logic [7:0] rev(input logic [7:0] v);
    return {<<{v}};
  endfunction : rev
  task automatic op(input logic w, o, input logic [7:0] s, d, input logic [8:0] e);
    exp_q.push_back(e);
    ma.access(w, o, s, d);
  endtask : op
  task automatic end_of_test();
    if (err_total == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : end_of_test
  always @(negedge clock) if (ack_q === 1'b1) begin
    if (exp_q.size() == 0) `CHK(ack_q, 1'b0)
    else begin
      exp_v = exp_q.pop_front();
      `CHK({err_q, rdata_q}, exp_v)
    end
  end
  always @(posedge clock) begin
    cyc++;
    if (cyc == 3000) begin
      err_total++;
      end_of_test();
    end
  end
  initial begin
    void'($urandom(34289));
    repeat (3) @(posedge clock);
    #1 rst = 1'b0;
    for (int o = 0; o < 2; o++) op(0, o[0], 8'h00, 8'h00, 9'h01e);
    op(1, 1, 8'h00, 8'h55, 9'h100);
    op(1, 0, 8'h01, 8'h55, 9'h100);
    op(0, 1, 8'h1f, 8'h00, 9'h100);
    for (int g = 1; g <= 30; g++) op(0, 1, 8'(g), 8'h00, 9'h0ff);
    `CHK(active_mask_q, {lgbm_pkg::BEAMS{1'b1}})
    for (int i = 0; i < 30; i++) beam_made[8*i +: 8] = 8'($urandom);
    ma.idle();
    ma.idle();
    for (int g = 1; g <= 30; g++) begin
      op(0, 0, 8'(g), 8'h00, {1'b0, rev(beam_made[8*g-8 +: 8])});
    end
    for (int g = 1; g <= 30; g++) begin
      m[g] = 8'($urandom);
      exp_act[8*g-8 +: 8] = rev(m[g]);
      op(1, 1, 8'(g), m[g], 9'h000);
    end
    ma.idle();
    repeat (11) @(posedge clock);
    #1;
    for (int g = 1; g <= 30; g++) `CHK(active_mask_q[8*g-8 +: 8], rev(m[g]))
    `CHK(watched_blocked_q, ~beam_made & exp_act)
    `CHK(status_pdo_q, beam_made)
    for (int g = 1; g <= 30; g++) op(0, 1, 8'(g), 8'h00, {1'b0, m[g]});
    ma.idle();
    ma.idle();
    // Second reset after writes: every mask byte returns to its reset value
    @(posedge clock);
    #1 rst = 1'b1;
    repeat (2) @(posedge clock);
    #1 rst = 1'b0;
    for (int g = 1; g <= 30; g++) op(0, 1, 8'(g), 8'h00, 9'h0ff);
    ma.idle();
    ma.idle();
    `CHK(active_mask_q, {lgbm_pkg::BEAMS{1'b1}})
    `CHK(exp_q.size(), 0)
    end_of_test();
  end
endmodule : tb_top
`default_nettype wire

// [verilog/lgbm_apply.sv]
// Timer that bounds the delay from a mask write to its effect
`timescale 1ns/10ps
`default_nettype none
module lgbm_apply #(
  parameter int APPLY_CYCLES = lgbm_pkg::APPLY_CYCLES
) (
  input wire logic clock,
  input wire logic rst,
  lgbm_apply_if.timer link
);
  localparam logic [lgbm_pkg::APPLY_CNT_W-1:0] LAST =
    lgbm_pkg::APPLY_CNT_W'(APPLY_CYCLES - 1);

  lgbm_pkg::lgbm_state_t state_q;
  logic [lgbm_pkg::APPLY_CNT_W-1:0] cnt_q;
  logic apply_q;

  assign link.apply_now = apply_q;

  ////////////////////////////////////////////////////////////////////////////
  // Count from the first pending write; later writes do not restart it,
  // so a stream of writes still lands inside the bound
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_q <= lgbm_pkg::LGBM_IDLE;
      cnt_q <= '0;
      apply_q <= 1'b0;
    end else begin
      apply_q <= 1'b0;
      unique case (state_q)
        lgbm_pkg::LGBM_IDLE: begin
          cnt_q <= '0;
          if (link.mask_written) begin
            state_q <= lgbm_pkg::LGBM_WAIT;
          end
        end
        lgbm_pkg::LGBM_WAIT: begin
          if (cnt_q >= LAST) begin
            apply_q <= 1'b1;
            cnt_q <= '0;
            // Write in the apply cycle opens a new wait
            if (!link.mask_written) begin
              state_q <= lgbm_pkg::LGBM_IDLE;
            end
          end else begin
            cnt_q <= cnt_q + 1'b1;
          end
        end
      endcase
    end
  end
endmodule : lgbm_apply
`default_nettype wire

// [verilog/lgbm_apply_if.sv]
// Handshake between the mask store and the apply timer
`timescale 1ns/10ps
`default_nettype none
interface lgbm_apply_if;
  logic mask_written;
  logic apply_now;
  modport store (output mask_written, input apply_now);
  modport timer (input mask_written, output apply_now);
endinterface : lgbm_apply_if
`default_nettype wire

// [verilog/lgbm_pkg.sv]
// Constants and types of the beam status and mask block
package lgbm_pkg;
  localparam int BEAMS = 240;
  localparam int GROUPS = 30;
  localparam int GROUP_BEAMS = 8;
  localparam logic OBJ_STATUS = 1'h0;
  localparam logic OBJ_MASK = 1'h1;
  localparam logic [7:0] SUB_COUNT_IDX = 8'h00;
  localparam logic [7:0] SUB_COUNT_VAL = 8'h1e;
  localparam logic [7:0] MASK_RST = 8'hff;
  localparam logic [7:0] MASK_OFF = 8'h00;
  localparam logic [7:0] STATUS_RST = 8'h00;
  localparam int CLK_HZ = 125_000_000;
  localparam int APPLY_TIME_MS = 650;
  // Longest time rounds down
  localparam int APPLY_CYCLES = APPLY_TIME_MS * (CLK_HZ / 1000);
  localparam int APPLY_CNT_W = 27;
  typedef enum logic [0:0] {
    LGBM_IDLE,
    LGBM_WAIT
  } lgbm_state_t;
endpackage : lgbm_pkg

// [verilog/lgbm_top.sv]
// Beam status readout and beam mask objects of a light grid receiver
//
// Contract
// - Status subindex n carries beams 8n-7 to 8n, 30 subindices, 240 beams.
// - Mask subindex 0 is read only and returns 30.
// - In a mask byte bit 7 is the lowest beam, bit 0 the highest.
// - Mask bit one keeps its beam active, zero deactivates it.
// - First mask byte resets to 255; higher bytes follow the beam count.
// - A written mask takes effect within 650 ms.
// - Beam 1 is on the connection side, for status and mask.
// - Mask subindices are read/write bytes of eight beams, not process data.
// - Mask subindices 3 to 30 cover beams 17 to 240 like status.
// - Status bytes are read only, reset to zero, exported as process data.
// - Each status subindex always covers a whole group of eight beams.
`timescale 1ns/10ps
`default_nettype none
module lgbm_top #(
  parameter int BEAM_COUNT = lgbm_pkg::BEAMS,
  parameter int APPLY_CYCLES = lgbm_pkg::APPLY_CYCLES
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic [lgbm_pkg::BEAMS-1:0] beam_made,
  input wire logic req,
  input wire logic req_write,
  input wire logic req_obj,
  input wire logic [7:0] req_sub,
  input wire logic [7:0] req_wdata,
  output logic ack_q,
  output logic err_q,
  output logic [7:0] rdata_q,
  output logic [lgbm_pkg::BEAMS-1:0] status_pdo_q,
  output logic [lgbm_pkg::BEAMS-1:0] active_mask_q,
  output logic [lgbm_pkg::BEAMS-1:0] watched_blocked_q
);
  ////////////////////////////////////////////////////////////////////////////
  // Decoding helpers

  // Data subindices run 1 to 30
  function automatic logic sub_is_data(input logic [7:0] sub);
    sub_is_data = (sub != lgbm_pkg::SUB_COUNT_IDX) && (sub <= lgbm_pkg::SUB_COUNT_VAL);
  endfunction : sub_is_data

  // Subindex 0 holds the entry count in both objects
  function automatic logic sub_is_count(input logic [7:0] sub);
    sub_is_count = (sub == lgbm_pkg::SUB_COUNT_IDX);
  endfunction : sub_is_count

  // Object select of an access
  function automatic logic obj_is_mask(input logic obj);
    obj_is_mask = (obj == lgbm_pkg::OBJ_MASK);
  endfunction : obj_is_mask

  // Reset byte of a mask group: bits for fitted beams set, others clear; group 0 is always 255
  // Unfitted beams past group 0 start masked so they never count as blocked
  function automatic logic [7:0] mask_reset(input int grp);
    logic [7:0] v;
    v = lgbm_pkg::MASK_OFF;
    for (int k = 0; k < lgbm_pkg::GROUP_BEAMS; k++) begin
      if (grp * lgbm_pkg::GROUP_BEAMS + k < BEAM_COUNT) begin
        v[7-k] = 1'b1;
      end
    end
    if (grp == 0) begin
      v = lgbm_pkg::MASK_RST;
    end
    mask_reset = v;
  endfunction : mask_reset

  ////////////////////////////////////////////////////////////////////////////
  // Storage; group g holds subindex g+1

  logic [7:0] status_q [lgbm_pkg::GROUPS];
  logic [7:0] mask_q [lgbm_pkg::GROUPS];
  logic [lgbm_pkg::BEAMS-1:0] mask_flat;
  logic [lgbm_pkg::BEAMS-1:0] status_flat;
  logic [4:0] grp_sel;
  logic do_write;
  logic wr_ok;
  logic rd_ok;
  logic boot_q;
  logic [7:0] rd_byte;

  lgbm_apply_if apply_link ();

  ////////////////////////////////////////////////////////////////////////////
  // Object access decode

  // Subindices above 30 wrap here; rd_ok and wr_ok keep them from use
  assign grp_sel = 5'(req_sub - 8'h01);
  // Status is read only; subindex 0 never written
  assign wr_ok = obj_is_mask(req_obj) && sub_is_data(req_sub);
  assign rd_ok = sub_is_count(req_sub) || sub_is_data(req_sub);
  // Only accepted writes reach the store and start the apply timer
  assign do_write = req && req_write && wr_ok;
  assign apply_link.mask_written = do_write;

  ////////////////////////////////////////////////////////////////////////////
  // Beam to byte mapping, beam 1 at the connection side in bit 7

  for (genvar g = 0; g < lgbm_pkg::GROUPS; g++) begin : g_grp
    for (genvar k = 0; k < lgbm_pkg::GROUP_BEAMS; k++) begin : g_bit
      // beam index g*8+k is beam g*8+k+1
      assign mask_flat[g*lgbm_pkg::GROUP_BEAMS+k] = mask_q[g][7-k];
      assign status_flat[g*lgbm_pkg::GROUP_BEAMS+k] = status_q[g][7-k];
    end

    // Whole byte sampled each cycle so a read is always one full group
    always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
        status_q[g] <= lgbm_pkg::STATUS_RST;
      end else begin
        for (int k = 0; k < lgbm_pkg::GROUP_BEAMS; k++) begin
          status_q[g][7-k] <= beam_made[g*lgbm_pkg::GROUP_BEAMS+k];
        end
      end
    end

    always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
        mask_q[g] <= mask_reset(g);
      end else if (do_write && grp_sel == 5'(g)) begin
        mask_q[g] <= req_wdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Object access answer, one cycle after the request

  // Read byte of the current request; zero unless a legal read
  always_comb begin
    rd_byte = 8'h00;
    if (req && !req_write && rd_ok) begin
      if (sub_is_count(req_sub)) begin
        rd_byte = lgbm_pkg::SUB_COUNT_VAL;
      end else if (obj_is_mask(req_obj)) begin
        rd_byte = mask_q[grp_sel];
      end else begin
        rd_byte = status_q[grp_sel];
      end
    end
  end

  // Every request is answered, refused ones too, so the master never waits
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ack_q <= 1'b0;
      err_q <= 1'b0;
    end else begin
      ack_q <= req;
      err_q <= req && (req_write ? !wr_ok : !rd_ok);
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= rd_byte;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Process data: status only; the mask never leaves as process data
  // Two edges from pin to image: one into the status byte, one here

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      status_pdo_q <= '0;
    end else begin
      status_pdo_q <= status_flat;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Effective mask, loaded late so the evaluation sees a settled set

  // Timer length is a parameter; the default is the longest allowed delay
  lgbm_apply #(
    .APPLY_CYCLES(APPLY_CYCLES)
  ) u_apply (
    .clock(clock),
    .rst(rst),
    .link(apply_link)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Start up

  // First edge after reset takes the reset mask without the apply delay,
  // since nothing has been written yet
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      boot_q <= 1'b1;
    end else begin
      boot_q <= 1'b0;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      active_mask_q <= '0;
    end else if (apply_link.apply_now || boot_q) begin
      active_mask_q <= mask_flat;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Evaluation output

  // Blocked beams inside the monitored area only
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      watched_blocked_q <= '0;
    end else begin
      watched_blocked_q <= ~beam_made & active_mask_q;
    end
  end
endmodule : lgbm_top
`default_nettype wire
